/* common/pse_i2c_pkg.sv */
// Shared constants and types for the serial register port and its master
package pse_i2c_pkg;
  localparam logic [6:0]  BASE_ADDR   = 7'h20;
  localparam logic [6:0]  GLOBAL_ADDR = 7'h40;
  localparam logic [6:0]  ARA_ADDR    = 7'h0C;
  localparam logic [7:0]  PTR_RESET   = 8'h00;
  localparam logic [7:0]  IDLE_BYTE   = 8'hFF;
  localparam logic [3:0]  MEAS_LO     = 4'h9;
  localparam logic [3:0]  MEAS_HI     = 4'hC;
  localparam logic [3:0]  PORT_FIRST  = 4'h1;
  localparam logic [3:0]  PORT_LAST   = 4'h4;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam int unsigned CLK_MHZ     = 50;
  localparam int unsigned QUARTER_NS  = 2500;
  localparam int unsigned QUARTER_CYC = (QUARTER_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {OP_WRITE, OP_READ, OP_READ16, OP_QUICK, OP_ARA} op_t;
endpackage

/* common/pse_i2c_if.sv */
// Two-wire bus, interrupt line and device reset between master and slave
`timescale 1ns/1ns
interface pse_i2c_if;
  logic scl;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic dev_int_oe;
  logic dev_rst_n;
  // Open drain: any enable pulls the line low
  wire  sda                 = ~(host_sda_oe | dev_sda_oe);
  wire  interrupt_request_n = ~dev_int_oe;
  modport dev  (input scl, input sda, input dev_rst_n, output dev_sda_oe, output dev_int_oe);
  modport host (output scl, output host_sda_oe, output dev_rst_n,
                input sda, input interrupt_request_n);
endinterface

/* design/pse_i2c_dev.sv */
// Slave end: serial register port with quads, global address and alert response
`timescale 1ns/1ns
// Summary of operation
// [RQ1] Base address is 0x20 ORed with pins
// [RQ2] Lowest address bit selects quad register set
// [RQ3] Single-byte read after pointer write
// [RQ4] Single-byte write after pointer byte
// [RQ5] Two-byte read only for measurement registers
// [RQ6] Measurement low byte first, then high
// [RQ7] Master acks first byte, nacks second
// [RQ8] Master prefers two-byte measurement reads
// [RQ9] STOP resets pointer to interrupt register
// [RQ10] Master does quick read for each quad
// [RQ11] Global address behaves like own address
// [RQ12] Master avoids reads through global address; the host does not block them, and the testbench reads through GLOBAL_ADDR
// [RQ13] Alert response acked only while interrupting
// [RQ14] Not interrupting: ignore alert response reads
// [RQ15] Alert byte is address plus one
// [RQ16] Abandon alert byte when one is overridden
// [RQ17] Winner releases interrupt, losers keep it
// [RQ18] No further alert answer until events clear
// [RQ19] Hold reset low during slow supply ramp
// [RQ20] Ignore all other addresses, stay undriven
module pse_i2c_dev (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  pse_i2c_if.dev          bus,
  input  wire logic [3:0] addr_pins_i,
  input  wire logic       event_pending_i,
  input  wire logic [7:0] rd_data_i,
  output logic            rd_req_o,
  output logic            wr_req_o,
  output logic            quad_select_bit_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      wr_data_o
);
  import pse_i2c_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ACK_ADDR, S_PTR, S_ACK_PTR, S_WDAT, S_ACK_WDAT,
    S_RDAT, S_MACK, S_NEXT, S_WAIT
  } dev_state_t;

  function automatic logic is_meas(input logic [7:0] a);
    is_meas = (a[7:4] >= PORT_FIRST) && (a[7:4] <= PORT_LAST) &&
              (a[3:0] >= MEAS_LO) && (a[3:0] <= MEAS_HI);
  endfunction

  dev_state_t  state_r;
  logic [1:0]  scl_sy_r;
  logic [1:0]  sda_sy_r;
  logic [3:0]  pin_sy_r;
  logic [3:0]  pin_r;
  logic        scl_d_r;
  logic        sda_d_r;
  logic [3:0]  cnt_r;
  logic [7:0]  shift_r;
  logic [7:0]  tx_r;
  logic [7:0]  ptr_r;
  logic        rw_r;
  logic        ara_r;
  logic        first_r;
  logic        more_r;
  logic        sda_oe_r;
  logic        int_oe_r;
  logic        ara_done_r;
  logic        rd_req_r;
  logic        wr_req_r;
  logic        quad_r;
  logic [7:0]  reg_addr_r;
  logic [7:0]  wr_data_r;

  wire scl_s    = scl_sy_r[1];
  wire sda_s    = sda_sy_r[1];
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire byte_end = (cnt_r == BYTE_BITS);
  // [RQ1] base address from pins
  wire [6:0] own_addr = BASE_ADDR | {2'b00, pin_r, 1'b0};
  // [RQ2] both quads share upper six bits
  wire hit_own  = (shift_r[7:2] == own_addr[6:1]);
  // [RQ11] global address treated as own
  wire hit_glob = (shift_r[7:1] == GLOBAL_ADDR);
  // [RQ13] alert read only while interrupting
  wire hit_ara  = (shift_r[7:1] == ARA_ADDR) & shift_r[0] & int_oe_r & ~ara_done_r;
  wire hit_any  = hit_own | hit_glob | hit_ara;
  // [RQ15] alert byte is address with one
  wire [7:0] ara_byte = {own_addr[6:1], quad_r, 1'b1};
  wire [7:0] rd_byte  = ara_r ? ara_byte : rd_data_i;
  // [RQ16] lost when released one reads low
  wire ara_lost = (state_r == S_RDAT) & scl_rise & ara_r & tx_r[7] & ~sda_s;
  wire ara_fin  = (state_r == S_RDAT) & scl_fall & byte_end & ara_r;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
      pin_sy_r <= 4'h0;
      pin_r    <= 4'h0;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
    end else begin
      scl_sy_r <= {scl_sy_r[0], bus.scl};
      sda_sy_r <= {sda_sy_r[0], bus.sda};
      pin_sy_r <= addr_pins_i;
      pin_r    <= pin_sy_r;
      scl_d_r  <= scl_s;
      sda_d_r  <= sda_s;
    end
  end

  // [RQ17] winner releases, loser keeps line
  // [RQ18] done flag holds until events clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ara_done_r <= 1'b0;
      int_oe_r   <= 1'b0;
    end else begin
      ara_done_r <= ara_fin | (ara_done_r & event_pending_i);
      int_oe_r   <= event_pending_i & ~ara_done_r & ~ara_fin;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    rd_req_r <= 1'b0;
    wr_req_r <= 1'b0;
    if (rst_i) begin
      state_r    <= S_IDLE;
      cnt_r      <= 4'h0;
      shift_r    <= 8'h00;
      tx_r       <= 8'h00;
      ptr_r      <= PTR_RESET;
      rw_r       <= 1'b0;
      ara_r      <= 1'b0;
      first_r    <= 1'b0;
      more_r     <= 1'b0;
      sda_oe_r   <= 1'b0;
      quad_r     <= 1'b0;
      reg_addr_r <= 8'h00;
      wr_data_r  <= 8'h00;
    end else if (stop_c) begin
      // [RQ9] pointer back to interrupt register
      state_r  <= S_IDLE;
      sda_oe_r <= 1'b0;
      ptr_r    <= PTR_RESET;
    end else if (start_c) begin
      state_r  <= S_ADDR;
      cnt_r    <= 4'h0;
      sda_oe_r <= 1'b0;
      ara_r    <= 1'b0;
    end else begin
      case (state_r)
        S_ADDR, S_PTR, S_WDAT: begin
          if (scl_rise && !byte_end) begin
            shift_r <= {shift_r[6:0], sda_s};
            cnt_r   <= cnt_r + 4'h1;
          end else if (scl_fall && byte_end) begin
            cnt_r <= 4'h0;
            if (state_r == S_ADDR) begin
              // [RQ14] [RQ20] unmatched address left alone
              if (hit_any) begin
                sda_oe_r <= 1'b1;
                state_r  <= S_ACK_ADDR;
                rw_r     <= shift_r[0];
                ara_r    <= hit_ara;
                if (!hit_ara) begin
                  quad_r <= hit_own & shift_r[1];
                end
                // [RQ3] fetch byte at current pointer
                if (shift_r[0] && !hit_ara) begin
                  rd_req_r   <= 1'b1;
                  reg_addr_r <= ptr_r;
                end
              end else begin
                state_r <= S_WAIT;
              end
            end else if (state_r == S_PTR) begin
              ptr_r    <= shift_r;
              sda_oe_r <= 1'b1;
              state_r  <= S_ACK_PTR;
            end else begin
              // [RQ4] one data byte written and acked
              wr_req_r   <= 1'b1;
              reg_addr_r <= ptr_r;
              wr_data_r  <= shift_r;
              sda_oe_r   <= 1'b1;
              state_r    <= S_ACK_WDAT;
            end
          end
        end
        S_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw_r) begin
              tx_r     <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
              first_r  <= 1'b1;
              state_r  <= S_RDAT;
            end else begin
              sda_oe_r <= 1'b0;
              state_r  <= S_PTR;
            end
          end
        end
        S_ACK_PTR: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            state_r  <= S_WDAT;
          end
        end
        S_ACK_WDAT: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            state_r  <= S_WAIT;
          end
        end
        S_RDAT: begin
          if (ara_lost) begin
            sda_oe_r <= 1'b0;
            state_r  <= S_WAIT;
          end else if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && byte_end) begin
            sda_oe_r <= 1'b0;
            state_r  <= S_MACK;
          end else if (scl_fall) begin
            tx_r     <= {tx_r[6:0], 1'b0};
            sda_oe_r <= ~tx_r[6];
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            state_r <= sda_s ? S_WAIT : S_NEXT;
            // [RQ5] [RQ6] high byte follows only for measurements
            more_r  <= first_r & ~ara_r & is_meas(ptr_r);
            first_r <= 1'b0;
            if (first_r && !ara_r && is_meas(ptr_r) && !sda_s) begin
              ptr_r      <= ptr_r + 8'h01;
              reg_addr_r <= ptr_r + 8'h01;
              rd_req_r   <= 1'b1;
            end
          end
        end
        S_NEXT: begin
          if (scl_fall) begin
            cnt_r    <= 4'h0;
            tx_r     <= more_r ? rd_data_i : IDLE_BYTE;
            sda_oe_r <= more_r ? ~rd_data_i[7] : 1'b0;
            state_r  <= S_RDAT;
          end
        end
        default: begin
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  assign bus.dev_sda_oe   = sda_oe_r;
  assign bus.dev_int_oe   = int_oe_r;
  assign rd_req_o         = rd_req_r;
  assign wr_req_o         = wr_req_r;
  assign quad_select_bit_o = quad_r;
  assign reg_addr_o       = reg_addr_r;
  assign wr_data_o        = wr_data_r;
endmodule

/* design/pse_i2c_host.sv */
// Master end: command-driven bus sequencer and device reset control
`timescale 1ns/1ns
module pse_i2c_host #(
  parameter int unsigned QUARTER_CYCLES = pse_i2c_pkg::QUARTER_CYC
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  pse_i2c_if.host               bus,
  input  wire logic             cmd_valid_i,
  input  wire pse_i2c_pkg::op_t op_i,
  input  wire logic [6:0]       dev_addr_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [7:0]       wr_data_i,
  input  wire logic             supply_ok_i,
  output logic                  cmd_ready_o,
  output logic                  done_o,
  output logic                  nack_o,
  output logic [15:0]           rd_data_o,
  output logic                  int_pending_o
);
  import pse_i2c_pkg::*;

  typedef enum logic [2:0] {K_START, K_TX, K_RXA, K_RXN, K_STOP} kind_t;

  function automatic kind_t step_kind(input op_t op, input logic [2:0] st);
    kind_t k;
    k = K_STOP;
    case (op)
      // [RQ4] address, pointer, data, stop
      OP_WRITE:  k = (st == 3'h0) ? K_START : (st <= 3'h3) ? K_TX : K_STOP;
      // [RQ3] pointer write, restart, one byte nacked
      OP_READ:   k = (st == 3'h0 || st == 3'h3) ? K_START : (st == 3'h5) ? K_RXN :
                     (st == 3'h6) ? K_STOP : K_TX;
      // [RQ7] [RQ8] first byte acked, second nacked
      OP_READ16: k = (st == 3'h0 || st == 3'h3) ? K_START : (st == 3'h5) ? K_RXA :
                     (st == 3'h6) ? K_RXN : (st == 3'h7) ? K_STOP : K_TX;
      default:   k = (st == 3'h0) ? K_START : (st == 3'h1) ? K_TX :
                     (st == 3'h2) ? K_RXN : K_STOP;
    endcase
    step_kind = k;
  endfunction

  function automatic logic [7:0] tx_byte(input op_t op, input logic [2:0] st,
                                         input logic [6:0] a, input logic [7:0] r,
                                         input logic [7:0] d);
    logic [7:0] b;
    b = {a, 1'b0};
    case (st)
      // [RQ10] [RQ12] quad bit and global reads left to caller
      3'h1:    b = (op == OP_ARA) ? {ARA_ADDR, 1'b1} : {a, (op == OP_QUICK)};
      3'h2:    b = r;
      3'h3:    b = d;
      3'h4:    b = {a, 1'b1};
      default: b = {a, 1'b0};
    endcase
    tx_byte = b;
  endfunction

  op_t         op_r;
  logic [6:0]  addr_r;
  logic [7:0]  reg_r;
  logic [7:0]  data_r;
  logic        busy_r;
  logic        abort_r;
  logic [2:0]  step_r;
  logic [1:0]  q_r;
  logic [3:0]  bit_r;
  logic [15:0] qcnt_r;
  logic [15:0] rx_r;
  logic        scl_r;
  logic        sda_oe_r;
  logic        ready_r;
  logic        done_r;
  logic        nack_r;
  logic [15:0] rd_data_r;
  logic [1:0]  sda_sy_r;
  logic [1:0]  int_sy_r;
  logic [1:0]  sup_sy_r;
  logic        rst_n_r;
  logic        int_r;

  wire        sda_s  = sda_sy_r[1];
  wire        tick   = busy_r & (qcnt_r == 16'h0000);
  wire kind_t kind   = abort_r ? K_STOP : step_kind(op_r, step_r);
  wire [7:0]  tx_w   = tx_byte(op_r, step_r, addr_r, reg_r, data_r);
  wire        data_b = (bit_r != BYTE_BITS);
  wire        tx_bit = tx_w[~bit_r[2:0]];

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sda_sy_r <= 2'h3;
      int_sy_r <= 2'h3;
      sup_sy_r <= 2'h0;
      rst_n_r  <= 1'b0;
      int_r    <= 1'b0;
    end else begin
      sda_sy_r <= {sda_sy_r[0], bus.sda};
      int_sy_r <= {int_sy_r[0], bus.interrupt_request_n};
      sup_sy_r <= {sup_sy_r[0], supply_ok_i};
      // [RQ19] device held in reset until supply good
      rst_n_r  <= sup_sy_r[1];
      int_r    <= ~int_sy_r[1];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    done_r <= 1'b0;
    if (rst_i) begin
      op_r      <= OP_WRITE;
      addr_r    <= 7'h00;
      reg_r     <= 8'h00;
      data_r    <= 8'h00;
      busy_r    <= 1'b0;
      abort_r   <= 1'b0;
      step_r    <= 3'h0;
      q_r       <= 2'h0;
      bit_r     <= 4'h0;
      qcnt_r    <= 16'h0000;
      rx_r      <= 16'h0000;
      scl_r     <= 1'b1;
      sda_oe_r  <= 1'b0;
      ready_r   <= 1'b0;
      nack_r    <= 1'b0;
      rd_data_r <= 16'h0000;
    end else if (!busy_r) begin
      ready_r <= ~cmd_valid_i;
      if (cmd_valid_i && ready_r) begin
        op_r    <= op_i;
        addr_r  <= dev_addr_i;
        reg_r   <= reg_addr_i;
        data_r  <= wr_data_i;
        busy_r  <= 1'b1;
        abort_r <= 1'b0;
        nack_r  <= 1'b0;
        step_r  <= 3'h0;
        q_r     <= 2'h0;
        bit_r   <= 4'h0;
        qcnt_r  <= 16'(QUARTER_CYCLES - 1);
      end
    end else begin
      qcnt_r <= tick ? 16'(QUARTER_CYCLES - 1) : qcnt_r - 16'h0001;
      if (tick) begin
        q_r <= q_r + 2'h1;
        case (q_r)
          2'h0: begin
            case (kind)
              K_START: sda_oe_r <= 1'b0;
              K_STOP:  sda_oe_r <= 1'b1;
              K_TX:    sda_oe_r <= data_b & ~tx_bit;
              K_RXA:   sda_oe_r <= ~data_b;
              default: sda_oe_r <= 1'b0;
            endcase
          end
          2'h1: scl_r <= 1'b1;
          2'h2: begin
            if (kind == K_START) begin
              sda_oe_r <= 1'b1;
            end else if (kind == K_STOP) begin
              sda_oe_r <= 1'b0;
            end else if (kind == K_TX && !data_b && sda_s) begin
              abort_r <= 1'b1;
              nack_r  <= 1'b1;
            end else if (kind != K_TX && data_b) begin
              // [RQ6] low byte shifted in first
              rx_r <= {rx_r[14:0], sda_s};
            end
          end
          default: begin
            // Nacked ack bit lowers the clock first, so a full STOP follows
            if (kind == K_STOP && data_b) begin
              busy_r    <= 1'b0;
              done_r    <= 1'b1;
              rd_data_r <= (op_r == OP_READ16) ? {rx_r[7:0], rx_r[15:8]} :
                                                 {8'h00, rx_r[7:0]};
            end else begin
              scl_r <= 1'b0;
              if (kind != K_START && data_b) begin
                bit_r <= bit_r + 4'h1;
              end else begin
                bit_r  <= 4'h0;
                step_r <= step_r + 3'h1;
              end
            end
          end
        endcase
      end
    end
  end

  assign bus.scl         = scl_r;
  assign bus.host_sda_oe = sda_oe_r;
  assign bus.dev_rst_n   = rst_n_r;
  assign cmd_ready_o     = ready_r;
  assign done_o          = done_r;
  assign nack_o          = nack_r;
  assign rd_data_o       = rd_data_r;
  assign int_pending_o   = int_r;
endmodule

/* verif/pse_i2c_sva.sv */
// Concurrent checks on the serial bus, interrupt line and device reset
`timescale 1ns/1ns
module pse_i2c_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic dev_int_oe,
  input wire logic dev_rst_n,
  input wire logic sda,
  input wire logic interrupt_request_n
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence start_seen;
    scl && $past(scl) && $fell(sda);
  endsequence

  sequence stop_seen;
    scl && $past(scl) && $rose(sda);
  endsequence

  a_rst_dev_silent: assert property (!dev_rst_n |=> !dev_sda_oe && !dev_int_oe)
    else $error("device drives a line while held in reset");
  a_ack_rise_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device pulls data low while clock high");
  a_ack_fall_low: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("device releases data while clock high");
  a_start_dev_free: assert property (start_seen |-> !dev_sda_oe)
    else $error("start condition caused by the device");
  a_stop_bus_idle: assert property (stop_seen |=> (!dev_sda_oe) [*8])
    else $error("device drives data after stop");
  a_sda_steady_high: assert property (
    scl && $past(scl) && (sda != $past(sda)) |-> (host_sda_oe != $past(host_sda_oe)))
    else $error("data changed by the device while clock high");
  a_scl_low_min: assert property ($fell(scl) |=> (!scl) [*8])
    else $error("clock low phase too short");
  a_scl_high_min: assert property ($rose(scl) |=> scl [*8])
    else $error("clock high phase too short");
  a_reset_bus_idle: assert property (
    $fell(rst_i) |-> scl && !host_sda_oe && !dev_sda_oe)
    else $error("bus not idle after reset");

  c_start: cover property (start_seen);
  c_dev_ack: cover property ($rose(dev_sda_oe));
  c_int_raise: cover property ($rose(dev_int_oe));
  c_int_drop: cover property ($fell(dev_int_oe) && interrupt_request_n == 1'b1);
endmodule

/* verif/tb_top.sv */
// Joins master and slave ends and runs the transfer sequences
`timescale 1ns/1ns
module tb_top;
  import pse_i2c_pkg::*;
  localparam logic [3:0] PINS = 4'h5;
  localparam logic [6:0] OWN0 = BASE_ADDR | {2'b00, PINS, 1'b0};
  localparam logic [6:0] OWN1 = OWN0 | 7'h01;
  localparam logic [7:0] RD_LIST  [5] = '{8'h19, 8'h4C, 8'h1D, 8'h06, 8'h39};
  localparam logic [6:0] BAD_LIST [4] = '{7'h2C, 7'h22, 7'h00, ARA_ADDR};
  logic        ref_clk_i, rst_i, cmd_valid_i, supply_ok_i, event_pending_i, dev_rst;
  logic        cmd_ready_o, done_o, nack_o, int_pending_o, rd_req_o, wr_req_o, quad_select_bit_o;
  op_t         op_i;
  logic [6:0]  dev_addr_i;
  logic [7:0]  reg_addr_i, wr_data_i, rd_data_i, reg_addr_o, wr_data_o, r, hi;
  logic [15:0] rd_data_o;
  logic [16:0] wr_log;
  logic [3:0]  pins;
  logic        meas;
  int          n_fail, tests_run, wr_cnt, rd_cnt, cnt, k;

  pse_i2c_if bus ();
  assign dev_rst = rst_i | ~bus.dev_rst_n;

  pse_i2c_host #(.QUARTER_CYCLES(8)) i_pse_i2c_host (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(bus), .cmd_valid_i(cmd_valid_i), .op_i(op_i),
    .dev_addr_i(dev_addr_i), .reg_addr_i(reg_addr_i), .wr_data_i(wr_data_i),
    .supply_ok_i(supply_ok_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .nack_o(nack_o),
    .rd_data_o(rd_data_o), .int_pending_o(int_pending_o));
  pse_i2c_dev i_pse_i2c_dev (
    .ref_clk_i(ref_clk_i), .rst_i(dev_rst), .bus(bus), .addr_pins_i(pins),
    .event_pending_i(event_pending_i), .rd_data_i(rd_data_i), .rd_req_o(rd_req_o),
    .wr_req_o(wr_req_o), .quad_select_bit_o(quad_select_bit_o), .reg_addr_o(reg_addr_o),
    .wr_data_o(wr_data_o));
  pse_i2c_sva i_pse_i2c_sva (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl(bus.scl), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_oe(bus.dev_sda_oe), .dev_int_oe(bus.dev_int_oe), .dev_rst_n(bus.dev_rst_n),
    .sda(bus.sda), .interrupt_request_n(bus.interrupt_request_n));

  // Register contents seen by the slave, distinct per quad and low seven address bits
  function automatic logic [7:0] regv(input logic q, input logic [7:0] a);
    return {q, a[6:0]} ^ 8'h5A;
  endfunction
  assign rd_data_i = regv(quad_select_bit_o, reg_addr_o);

  always @(posedge ref_clk_i) begin
    if (wr_req_o === 1'b1) begin
      wr_log <= {quad_select_bit_o, reg_addr_o, wr_data_o};
      wr_cnt <= wr_cnt + 1;
    end
    if (rd_req_o === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
    end
  end

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_i);
    #2;
  endtask

  task automatic run(input op_t op, input logic [6:0] a, input logic [7:0] ra,
                     input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 200) begin
      cycles(1);
      n++;
    end
    if (n >= 200) begin
      n_fail++;
      complete_run();
    end
    op_i = op;
    dev_addr_i = a;
    reg_addr_i = ra;
    wr_data_i = d;
    cmd_valid_i = 1'b1;
    cycles(1);
    cmd_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 5200) begin
      cycles(1);
      n++;
    end
    if (n >= 5200) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic wait_int(input logic lvl);
    int n;
    n = 0;
    while (int_pending_o !== lvl && n < 200) begin
      cycles(1);
      n++;
    end
    check(int_pending_o, lvl);
    if (n >= 200) begin
      complete_run();
    end
  endtask

  initial begin
    rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    supply_ok_i = 1'b0;
    event_pending_i = 1'b0;
    op_i = OP_WRITE;
    dev_addr_i = 7'h00;
    reg_addr_i = 8'h00;
    wr_data_i = 8'h00;
    wr_cnt = 0;
    rd_cnt = 0;
    pins = PINS;
    cycles(3);
    rst_i = 1'b0;
    cycles(12);
    supply_ok_i = 1'b1;
    cycles(10);
    run(OP_WRITE, OWN0, 8'h14, 8'h3C);
    check({nack_o, wr_log}, {2'b00, 8'h14, 8'h3C});
    check({bus.scl, bus.sda}, 18'h3);
    run(OP_WRITE, OWN1, 8'h24, 8'hC3);
    check({nack_o, wr_log}, {2'b01, 8'h24, 8'hC3});
    $display("write tests finished");
    run(OP_READ, OWN1, 8'h05, 8'h00);
    check({nack_o, rd_data_o}, {1'b0, 8'h00, regv(1'b1, 8'h05)});
    for (k = 0; k < 5; k++) begin
      r = RD_LIST[k];
      meas = (r[7:4] >= PORT_FIRST) && (r[7:4] <= PORT_LAST) && (r[3:0] >= MEAS_LO)
             && (r[3:0] <= MEAS_HI);
      hi = meas ? regv(1'b0, r + 8'h01) : IDLE_BYTE;
      cnt = rd_cnt;
      run(OP_READ16, OWN0, r, 8'h00);
      check({nack_o, rd_data_o}, {1'b0, hi, regv(1'b0, r)});
      check(18'(rd_cnt - cnt), {17'h00000, meas} + 18'h00001);
    end
    $display("read tests finished");
    for (k = 0; k < 2; k++) begin
      run(OP_QUICK, OWN0 | k[6:0], 8'h00, 8'h00);
      check({nack_o, rd_data_o}, {1'b0, 8'h00, regv(k[0], PTR_RESET)});
    end
    run(OP_WRITE, GLOBAL_ADDR, 8'h15, 8'hA5);
    check({nack_o, wr_log}, {2'b00, 8'h15, 8'hA5});
    run(OP_READ, GLOBAL_ADDR, 8'h07, 8'h00);
    check({nack_o, rd_data_o}, {1'b0, 8'h00, regv(1'b0, 8'h07)});
    for (k = 0; k < 4; k++) begin
      cnt = wr_cnt;
      run(OP_WRITE, BAD_LIST[k], 8'h14, 8'h77);
      check({nack_o, wr_cnt == cnt}, 18'h3);
    end
    run(OP_ARA, ARA_ADDR, 8'h00, 8'h00);
    check({nack_o, bus.dev_sda_oe}, 18'h2);
    $display("address tests finished");
    event_pending_i = 1'b1;
    wait_int(1'b1);
    run(OP_QUICK, OWN0, 8'h00, 8'h00);
    run(OP_ARA, ARA_ADDR, 8'h00, 8'h00);
    check({nack_o, rd_data_o, bus.interrupt_request_n}, {9'h000, OWN0, 2'b11});
    run(OP_ARA, ARA_ADDR, 8'h00, 8'h00);
    check({nack_o, bus.interrupt_request_n}, 18'h3);
    event_pending_i = 1'b0;
    cycles(5);
    event_pending_i = 1'b1;
    wait_int(1'b1);
    run(OP_ARA, ARA_ADDR, 8'h00, 8'h00);
    check({nack_o, rd_data_o}, {2'b00, 8'h00, OWN0, 1'b1});
    $display("alert tests finished");
    pins = 4'hA;
    cycles(4);
    cnt = wr_cnt;
    run(OP_WRITE, OWN0, 8'h14, 8'h66);
    check({nack_o, wr_cnt == cnt}, 18'h3);
    run(OP_WRITE, BASE_ADDR | {2'b00, 4'hA, 1'b0}, 8'h14, 8'h5C);
    check({nack_o, wr_log}, {2'b00, 8'h14, 8'h5C});
    $display("pin tests finished");
    complete_run();
  end
endmodule
